// File: spx_defs.svh
`ifndef SPX_DEFS_SVH
`define SPX_DEFS_SVH

// opcode fields
`define SPX_OP_PUSH_HI      8'hfa
`define SPX_OP_SUBPTR_HI    8'he9
`define SPX_SEL_RETURN      2'h3
`define SPX_SEL_MSB         7
`define SPX_SEL_LSB         6
`define SPX_LIT6_MSB        5

// widths and reset values
`define SPX_PTR_W           12
`define SPX_PC_W            21
`define SPX_PTR_RESET       12'h000
`define SPX_PC_RESET        21'h000000
`define SPX_NUM_PTR         3

`endif

// File: spx_pkg.sv
package spx_pkg;
    `include "spx_defs.svh"

    typedef enum logic [1:0] {
        SPX_OP_NONE   = 2'b00,
        SPX_OP_PUSH   = 2'b01,
        SPX_OP_SUBPTR = 2'b10,
        SPX_OP_SUBRET = 2'b11
    } spx_op_t;

    typedef enum logic [0:0] {
        SPX_ST_RUN   = 1'b0,
        SPX_ST_FLUSH = 1'b1
    } spx_state_t;

    // one data memory write request
    typedef struct packed {
        logic                    en;
        logic [`SPX_PTR_W-1:0]   addr;
        logic [7:0]              data;
    } spx_mem_wr_t;

    // program counter redirect request
    typedef struct packed {
        logic                    en;
        logic [`SPX_PC_W-1:0]    target;
    } spx_pc_load_t;
endpackage

// File: spx_ptr_file.sv
`timescale 1ns/1ps

// ****************************************************************
// pointer register file
// ****************************************************************
module spx_ptr_file
    import spx_pkg::*;
(
    input  wire logic                  ref_clk_i,  // core clock
    input  wire logic                  reset_i,    // async reset, high
    input  wire logic                  wr_en_i,    // write strobe
    input  wire logic [1:0]            wr_sel_i,   // pointer to write
    input  wire logic [`SPX_PTR_W-1:0] wr_data_i,  // new pointer value
    output logic [`SPX_NUM_PTR*`SPX_PTR_W-1:0] ptr_o // all pointers, registered
);
    genvar g;
    generate
        for (g = 0; g < `SPX_NUM_PTR; g++) begin : g_ptr
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    ptr_o[g*`SPX_PTR_W +: `SPX_PTR_W] <= `SPX_PTR_RESET;
                end else if (wr_en_i && wr_sel_i == 2'(g)) begin
                    ptr_o[g*`SPX_PTR_W +: `SPX_PTR_W] <= wr_data_i;
                end
            end
        end
    endgenerate
endmodule

// File: spx_core.sv
`timescale 1ns/1ps
// How it works
// [RULE1] push writes low-byte literal at pointer two
// [RULE2] push then decrements pointer two, one cycle
// [RULE3] subtract six-bit literal from selected pointer
// [RULE4] selectors 0..2 pick matching pointer
// [RULE5] selector 11 decodes as subtract-and-return
// [RULE6] subtract-and-return loads pc, flushes one cycle
// [RULE7] execute only when extended set enabled
// [RULE8] pointer math wraps at twelve bits

module spx_core
    import spx_pkg::*;
(
    input  wire logic                  ref_clk_i,            // core clock, 10 MHz
    input  wire logic                  reset_i,              // async reset, high
    input  wire logic                  instr_valid_i,        // opcode valid this cycle
    input  wire logic [15:0]           instr_i,              // opcode word
    input  wire logic                  extended_set_enable_i,// extension config bit
    input  wire logic [`SPX_PC_W-1:0]  return_stack_top_i,   // top of return stack
    output logic                       mem_wr_en_o,          // data memory write strobe
    output logic [`SPX_PTR_W-1:0]      mem_wr_addr_o,        // data memory write address
    output logic [7:0]                 mem_wr_data_o,        // data memory write data
    output logic                       pc_load_o,            // load pc from return stack
    output logic [`SPX_PC_W-1:0]       pc_target_o,          // new pc value
    output logic                       return_pop_o,         // pop return stack
    output logic                       flush_o,              // second cycle is a nop
    output logic                       handled_o,            // opcode executed here
    output logic [`SPX_NUM_PTR*`SPX_PTR_W-1:0] file_select_pointer_o // pointers 0..2
);
    // ****************************************************************
    // decode
    // ****************************************************************
    spx_op_t                op;
    spx_state_t             state_q;
    logic [1:0]             sel;
    logic [`SPX_PTR_W-1:0]  lit6;
    logic [`SPX_PTR_W-1:0]  cur_ptr;
    logic [`SPX_PTR_W-1:0]  new_ptr;
    logic                   ptr_wr;
    logic [`SPX_NUM_PTR*`SPX_PTR_W-1:0] ptrs;
    logic [`SPX_PTR_W-1:0]  stack_pointer_two;
    spx_mem_wr_t            mem_wr_d;
    spx_pc_load_t           pc_ld_d;

    assign stack_pointer_two = ptrs[2*`SPX_PTR_W +: `SPX_PTR_W];
    // the literal is unsigned, so it is zero-extended before the subtract
    assign lit6 = {{(`SPX_PTR_W-6){1'b0}}, instr_i[`SPX_LIT6_MSB:0]};

    always_comb begin
        op = SPX_OP_NONE;
        // a fetched word in the flush slot is discarded, not executed
        if (instr_valid_i && extended_set_enable_i && state_q == SPX_ST_RUN) begin // see [RULE7]
            if (instr_i[15:8] == `SPX_OP_PUSH_HI) begin
                op = SPX_OP_PUSH;
            end else if (instr_i[15:8] == `SPX_OP_SUBPTR_HI) begin
                if (instr_i[`SPX_SEL_MSB:`SPX_SEL_LSB] == `SPX_SEL_RETURN) begin
                    op = SPX_OP_SUBRET; // see [RULE5]
                end else begin
                    op = SPX_OP_SUBPTR;
                end
            end
        end
    end

    // ****************************************************************
    // pointer arithmetic
    // ****************************************************************
    always_comb begin
        sel    = 2'h2;
        ptr_wr = 1'b0;
        case (op)
            SPX_OP_PUSH: begin
                ptr_wr = 1'b1;
            end
            SPX_OP_SUBPTR: begin
                sel    = instr_i[`SPX_SEL_MSB:`SPX_SEL_LSB]; // see [RULE4]
                ptr_wr = 1'b1;
            end
            SPX_OP_SUBRET: begin
                ptr_wr = 1'b1; // see [RULE5]
            end
            default: begin
                ptr_wr = 1'b0;
            end
        endcase
        cur_ptr = ptrs[sel*`SPX_PTR_W +: `SPX_PTR_W];
        // modulo 4096: the 12-bit difference simply wraps
        if (op == SPX_OP_PUSH) begin
            new_ptr = cur_ptr - 12'h001; // see [RULE2] [RULE8]
        end else begin
            new_ptr = cur_ptr - lit6; // see [RULE3] [RULE8]
        end
    end

    // ****************************************************************
    // pointer register file
    // ****************************************************************
    // one write port: no operation here touches two pointers at once
    spx_ptr_file u_ptr_file (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .wr_en_i   (ptr_wr),
        .wr_sel_i  (sel),
        .wr_data_i (new_ptr),
        .ptr_o     (ptrs)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb begin
        mem_wr_d.en   = (op == SPX_OP_PUSH); // see [RULE1]
        mem_wr_d.addr = stack_pointer_two;   // pre-decrement address, see [RULE1]
        mem_wr_d.data = instr_i[7:0];
        pc_ld_d.en     = (op == SPX_OP_SUBRET); // see [RULE6]
        pc_ld_d.target = return_stack_top_i;
    end

    // ****************************************************************
    // data memory write port
    // ****************************************************************
    // the strobe is a one-cycle pulse; address and data follow the decode
    // freely since nothing downstream looks at them without the strobe
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_wr_en_o <= 1'b0;
        end else begin
            mem_wr_en_o <= mem_wr_d.en; // see [RULE1]
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_wr_addr_o <= `SPX_PTR_RESET;
        end else begin
            mem_wr_addr_o <= mem_wr_d.addr;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_wr_data_o <= 8'h00;
        end else begin
            mem_wr_data_o <= mem_wr_d.data;
        end
    end

    // ****************************************************************
    // return path
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_load_o <= 1'b0;
        end else begin
            pc_load_o <= pc_ld_d.en; // see [RULE6]
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_target_o <= `SPX_PC_RESET;
        end else begin
            pc_target_o <= pc_ld_d.target;
        end
    end

    // pop and load come from one decode, so the stack and the pc never
    // disagree about which return was taken
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            return_pop_o <= 1'b0;
        end else begin
            return_pop_o <= pc_ld_d.en;
        end
    end

    // ****************************************************************
    // flush slot
    // ****************************************************************
    // the word fetched behind a return is dropped
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= SPX_ST_RUN;
        end else begin
            case (state_q)
                SPX_ST_RUN: begin
                    if (op == SPX_OP_SUBRET) begin
                        state_q <= SPX_ST_FLUSH; // see [RULE6]
                    end
                end
                SPX_ST_FLUSH: begin
                    state_q <= SPX_ST_RUN;
                end
                default: begin
                    state_q <= SPX_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flush_o <= 1'b0;
        end else begin
            flush_o <= (op == SPX_OP_SUBRET); // see [RULE6]
        end
    end

    // ****************************************************************
    // completion and pointer view
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            handled_o <= 1'b0;
        end else begin
            handled_o <= (op != SPX_OP_NONE); // see [RULE7]
        end
    end

    // pointers already leave the file from flops, so no second copy here
    assign file_select_pointer_o = ptrs;
endmodule

// File: spx_core_monitor.sv
`timescale 1ns/1ps
`include "spx_defs.svh"
module spx_core_monitor
    import spx_pkg::*;
(
    input wire logic        ref_clk_i,             // clk
    input wire logic        reset_i,               // rst
    input wire logic        instr_valid_i,         // in
    input wire logic [15:0] instr_i,               // in
    input wire logic        extended_set_enable_i, // in
    input wire logic [20:0] return_stack_top_i,    // in
    input wire logic        mem_wr_en_o,           // out
    input wire logic [11:0] mem_wr_addr_o,         // out
    input wire logic [7:0]  mem_wr_data_o,         // out
    input wire logic        pc_load_o,             // out
    input wire logic [20:0] pc_target_o,           // out
    input wire logic        return_pop_o,          // out
    input wire logic        flush_o,               // out
    input wire logic        handled_o,             // out
    input wire logic [35:0] file_select_pointer_o  // out
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    function automatic logic [11:0] ptr(logic [35:0] f, logic [1:0] s);
        return f[s*12 +: 12];
    endfunction
    wire        go  = instr_valid_i && extended_set_enable_i && !flush_o;
    wire        psh = go && instr_i[15:8] == `SPX_OP_PUSH_HI;
    wire        sub = go && instr_i[15:8] == `SPX_OP_SUBPTR_HI;
    wire        ret = sub && instr_i[7:6] == `SPX_SEL_RETURN;
    wire [1:0]  sl  = ret ? 2'h2 : instr_i[7:6];
    wire [11:0] k6  = {6'h00, instr_i[5:0]};
    wire [11:0] p2  = file_select_pointer_o[35:24];
    wire [11:0] ps  = ptr(file_select_pointer_o, sl);
    wire [35:0] msk = 36'hfff << (12 * sl);
    sequence s_ret_take; ret; endsequence
    sequence s_ret_done;
        pc_load_o && return_pop_o && flush_o && pc_target_o == $past(return_stack_top_i);
    endsequence
    property p_push_wr;
        psh |=> mem_wr_en_o && mem_wr_addr_o == $past(p2) && mem_wr_data_o == $past(instr_i[7:0]);
    endproperty
    property p_push_dec; psh |=> handled_o && !pc_load_o && p2 == $past(p2) - 12'h001; endproperty
    property p_sub; sub |=> ptr(file_select_pointer_o, $past(sl)) == $past(ps) - $past(k6); endproperty
    property p_others;
        sub |=> !mem_wr_en_o && (file_select_pointer_o & ~$past(msk))
            == ($past(file_select_pointer_o) & ~$past(msk));
    endproperty
    property p_ret; s_ret_take |=> s_ret_done ##1 !pc_load_o && !flush_o; endproperty
    property p_none; sub && !ret |=> handled_o && !pc_load_o && !flush_o; endproperty
    property p_flush; flush_o |=> !handled_o && $stable(file_select_pointer_o); endproperty
    property p_off;
        !extended_set_enable_i |=> !handled_o && !mem_wr_en_o && $stable(file_select_pointer_o);
    endproperty
    a_push_wr:  assert property (p_push_wr)  else $error("push write wrong");
    a_push_dec: assert property (p_push_dec) else $error("push decrement wrong");
    a_sub:      assert property (p_sub)      else $error("subtract wrong");
    a_others:   assert property (p_others)   else $error("wrong pointer hit");
    a_ret:      assert property (p_ret)      else $error("return wrong");
    a_none:     assert property (p_none)     else $error("subtract returned");
    a_flush:    assert property (p_flush)    else $error("flush slot ran");
    a_off:      assert property (p_off)      else $error("ran while disabled");
endmodule
bind spx_core spx_core_monitor u_mon (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .extended_set_enable_i(extended_set_enable_i),
    .return_stack_top_i(return_stack_top_i), .mem_wr_en_o(mem_wr_en_o),
    .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o), .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o), .return_pop_o(return_pop_o), .flush_o(flush_o),
    .handled_o(handled_o), .file_select_pointer_o(file_select_pointer_o));

// File: tb.sv
`timescale 1ns/1ps
`include "spx_defs.svh"
module tb;
    logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, xen = 1'b0, slot = 1'b0;
    logic [15:0] ins = 16'h0000;
    logic [20:0] return_stack_top = 21'h000000, pct;
    logic        we, pcl, pop, fl, hd;
    logic [11:0] wa, p[3];
    logic [7:0]  wd;
    logic [35:0] fsp;
    logic [80:0] exq[$], wx, wy;
    logic [31:0] r;
    int          errors = 0, n_checks = 0;
    spx_core DUT (.ref_clk_i(clk), .reset_i(rst), .instr_valid_i(vld), .instr_i(ins),
        .extended_set_enable_i(xen), .return_stack_top_i(return_stack_top), .mem_wr_en_o(we),
        .mem_wr_addr_o(wa), .mem_wr_data_o(wd), .pc_load_o(pcl), .pc_target_o(pct),
        .return_pop_o(pop), .flush_o(fl), .handled_o(hd), .file_select_pointer_o(fsp));
    initial forever #50 clk = ~clk;
    task automatic check(string nm, logic [80:0] seen, logic [80:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // the model keeps its own pointer copies; expectations never read the outputs
    task automatic issue(logic [15:0] op, logic e);
        logic [80:0] x;
        logic [1:0]  s;
        logic        tk;
        @(negedge clk);
        vld = 1'b1;
        ins = op;
        xen = e;
        return_stack_top = 21'($urandom);
        s = op[7:6];
        tk = e && !slot && (op[15:8] == `SPX_OP_PUSH_HI || op[15:8] == `SPX_OP_SUBPTR_HI);
        slot = tk && op[15:8] == `SPX_OP_SUBPTR_HI && s == `SPX_SEL_RETURN;
        x = '0;
        if (tk && op[15:8] == `SPX_OP_PUSH_HI) begin
            x[80:60] = {1'b1, p[2], op[7:0]};
            p[2] = p[2] - 12'h001;
        end else if (tk) begin
            if (slot) s = 2'h2;
            p[s] = p[s] - {6'h00, op[5:0]};
            if (slot) x[59:36] = {3'b111, return_stack_top};
        end
        x[35:0] = {p[2], p[1], p[0]};
        if (tk) exq.push_back(x);
    endtask
    task automatic idle;
        @(negedge clk);
        vld = 1'b0;
        slot = 1'b0;
    endtask
    // a pulse without the handled flag, or an unknown flag, is a fault as well
    always @(negedge clk) if (!rst) begin
        if (hd !== 1'b0) begin
            if (exq.size() == 0) check("handled", 81'(hd), 81'h0);
            else begin
                check("handled", 81'(hd), 81'h1);
                wx = exq.pop_front();
                wy = {we, wa, wd, pcl, pop, fl, pct, fsp};
                if (!wx[80]) wy[79:60] = wx[79:60];
                if (!wx[59]) wy[56:36] = wx[56:36];
                check("result", wy, wx);
            end
        end else begin
            check("quiet pulses", 81'({we, pcl, pop, fl}), 81'h0);
        end
    end
    initial begin
        #1000000;
        errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(10953));
        p = '{default: 12'h000};
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        issue(16'hfa08, 1'b1);
        issue(16'hfa5a, 1'b1);
        idle;
        $display("push wrap test done");
        for (int s = 0; s < 4; s++) begin
            issue({8'he9, 2'(s), 6'h00}, 1'b1);
            issue({8'he9, 2'(s), 6'h3f}, 1'b1);
        end
        issue(16'he9e3, 1'b1);
        issue(16'hfa11, 1'b1);
        issue(16'hfa22, 1'b1);
        idle;
        $display("subtract and return test done");
        repeat (400) begin
            r = $urandom;
            issue({r[1] ? r[15:8] : (r[0] ? 8'hfa : 8'he9), r[23:16]}, r[31:28] != 4'h0);
        end
        idle;
        repeat (2) @(negedge clk);
        check("drained", 81'(exq.size()), 81'h0);
        $display("random mix test done");
        report_and_stop;
    end
endmodule
